/* File: src/gp_timer_regs.svh */
// Constants for the general purpose timer.
// Assumes it is included by the timer module.
// Behaviour
// - Sixteen-bit counter: up, down or center
// - Up mode wraps to zero at reload
// - Down mode reloads at zero
// - Wrap raises update, loads buffered settings
// - Update disable blocks update events
// - Center mode flags at reload-1 and 1
// - Prescaler divides clock by 1 to 65536
// - Prescaler ratio buffered until update
// - Kernel clock drives the prescaler directly
// - Four capture/compare channels, own value
// - Capture path: filter, edge, event prescaler
// - Capture after event divide sets channel event flag
// - Output mode selects eight compare behaviours
// - Match drives, clears or toggles output
// - Flag with enable gives interrupt, DMA
// - PWM period from reload, width compare
// - PWM1 active while counter below compare
// - PWM2 inactive while counter below compare
// - Codes 100, 101 force reference
// - Forced modes still flag on match
// - Reload preload decides immediate or update
`ifndef GP_TIMER_REGS_SVH
`define GP_TIMER_REGS_SVH
`define CNT_W 16
`define CH_N 4
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define DIR_UP 2'h0
`define DIR_DOWN 2'h1
`define FILT_W 4
`define ICPSC_W 2
`endif

/* File: src/gp_timer_pkg.sv */
// Types for the general purpose timer.
// Assumes nothing beyond the constants header.
package gp_timer_pkg;
  typedef enum logic [2:0] {
    OM_FREEZE, OM_ACT, OM_INACT, OM_TOGGLE,
    OM_FORCE_LO, OM_FORCE_HI, OM_PWM1, OM_PWM2
  } out_mode_t;
endpackage

/* File: src/general_purpose_timer.sv */
// Sixteen-bit timer with time base and four capture/compare channels.
// Assumes capture pins are asynchronous; all else on the kernel clock.
`timescale 1ns/1ps
`include "gp_timer_regs.svh"
module general_purpose_timer #(
  parameter int CW = `CNT_W,
  parameter int NCH = `CH_N
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Time base control
  input wire logic counterRunEnable,
  input wire logic [1:0] countDirectionSelect,
  input wire logic updateDisable,
  input wire logic reloadPreloadEnable,
  input wire logic [CW-1:0] autoReloadValue,
  input wire logic [CW-1:0] prescalerValue,
  // Channel configuration
  input wire logic [NCH-1:0] channelIsCapture,
  input wire logic [NCH-1:0] channelCaptureFalling,
  input wire logic [NCH*`FILT_W-1:0] channelFilterLength,
  input wire logic [NCH*`ICPSC_W-1:0] channelEventDivide,
  input wire logic [NCH*3-1:0] channelOutputMode,
  input wire logic [NCH-1:0] channelOutputPolarity,
  input wire logic [NCH-1:0] channelIrqEnable,
  input wire logic channelDmaSelect,
  input wire logic [NCH*CW-1:0] channelCompareWrite,
  input wire logic [NCH-1:0] channelCompareWriteStrobe,
  input wire logic [NCH-1:0] channelFlagClear,
  // Pins
  input wire logic [NCH-1:0] captureIn,
  // Status and outputs
  output logic [CW-1:0] counterValue,
  output logic updateEvent,
  output logic [NCH*CW-1:0] channelCompareValue,
  output logic [NCH-1:0] channelEventFlag,
  output logic [NCH-1:0] channelReferenceOutput,
  output logic [NCH-1:0] channelOut,
  output logic irqRequest,
  output logic dmaRequest
);

  function automatic logic [CW-1:0] chVal(input logic [NCH*CW-1:0] v,
                                          input int i);
    chVal = v[i*CW +: CW];
  endfunction

  // Time base state
  logic [CW-1:0] cnt_q, cnt_d;
  logic [CW-1:0] psc_q, pscAct_q, arrAct_q;
  logic downDir_q, downDir_d;
  logic upd_q;

  wire logic [CW-1:0] arrEff = reloadPreloadEnable ? arrAct_q
                                                   : autoReloadValue;
  wire logic center = countDirectionSelect[1];
  wire logic isDown = (countDirectionSelect == `DIR_DOWN);
  // Kernel clock feeds the prescaler with no slave stage
  wire logic tick = counterRunEnable && (psc_q == pscAct_q);
  wire logic [CW-1:0] arrM1 = arrEff - `CNT_ONE;
  wire logic ovUp = tick && !center && !isDown && (cnt_q >= arrEff);
  wire logic unDn = tick && isDown && (cnt_q == `CNT_ZERO);
  wire logic ovCa = tick && center && !downDir_q && (cnt_q == arrM1);
  wire logic unCa = tick && center && downDir_q && (cnt_q == `CNT_ONE);
  wire logic wrap = ovUp || unDn || ovCa || unCa;
  wire logic updNow = wrap && !updateDisable;

  always_comb begin
    cnt_d = cnt_q;
    downDir_d = downDir_q;
    if (tick) begin
      if (center) begin
        if (!downDir_q) begin
          cnt_d = cnt_q + `CNT_ONE;
          if (cnt_q + `CNT_ONE >= arrEff) downDir_d = 1'b1;
        end else begin
          cnt_d = cnt_q - `CNT_ONE;
          if (cnt_q == `CNT_ONE) downDir_d = 1'b0;
        end
      end else if (isDown) begin
        cnt_d = unDn ? arrEff : cnt_q - `CNT_ONE;
      end else begin
        cnt_d = ovUp ? `CNT_ZERO : cnt_q + `CNT_ONE;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= `CNT_ZERO;
      downDir_q <= 1'b0;
      psc_q <= `CNT_ZERO;
      pscAct_q <= `CNT_ZERO;
      arrAct_q <= `CNT_ZERO;
      upd_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      downDir_q <= downDir_d;
      // Divide by active ratio plus one, 1 to 65536
      if (counterRunEnable) psc_q <= tick ? `CNT_ZERO : psc_q + `CNT_ONE;
      if (updNow) begin
        pscAct_q <= prescalerValue;
        arrAct_q <= autoReloadValue;
      end
      upd_q <= updNow;
    end
  end

  // Capture input path: sync, filter, edge, event divide
  logic [NCH-1:0] sync1_q, sync2_q, filt_q, filtPrev_q;
  logic [`FILT_W-1:0] fcnt_q [NCH];
  logic [`ICPSC_W-1:0] evc_q [NCH];
  logic [NCH*CW-1:0] ccr_q;
  logic [NCH-1:0] flag_q, ref_q;
  wire logic [NCH-1:0] edgeSeen, capFire, match, fire;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gch
      wire logic [`FILT_W-1:0] flen = channelFilterLength[g*`FILT_W +: `FILT_W];
      wire logic [`ICPSC_W-1:0] ediv =
        channelEventDivide[g*`ICPSC_W +: `ICPSC_W];
      wire logic [CW-1:0] ccv = chVal(ccr_q, g);
      wire logic rise = filt_q[g] && !filtPrev_q[g];
      wire logic fall = !filt_q[g] && filtPrev_q[g];
      assign edgeSeen[g] = channelIsCapture[g]
        && (channelCaptureFalling[g] ? fall : rise);
      // Divide 1,2,4,4 events per capture
      wire logic [`ICPSC_W-1:0] evMask =
        `ICPSC_W'((1 << ediv) - 1);
      assign capFire[g] = edgeSeen[g] && ((evc_q[g] & evMask) == evMask);
      assign match[g] = !channelIsCapture[g] && (cnt_q == ccv) && tick;
      assign fire[g] = capFire[g] || match[g];
      wire logic [2:0] om = channelOutputMode[g*3 +: 3];
      wire logic below = cnt_q < ccv;
      logic refNext;
      always_comb begin
        refNext = ref_q[g];
        case (gp_timer_pkg::out_mode_t'(om))
          gp_timer_pkg::OM_FREEZE: refNext = ref_q[g];
          gp_timer_pkg::OM_ACT: if (match[g]) refNext = 1'b1;
          gp_timer_pkg::OM_INACT: if (match[g]) refNext = 1'b0;
          gp_timer_pkg::OM_TOGGLE: if (match[g]) refNext = !ref_q[g];
          gp_timer_pkg::OM_FORCE_LO: refNext = 1'b0;
          gp_timer_pkg::OM_FORCE_HI: refNext = 1'b1;
          gp_timer_pkg::OM_PWM1: refNext = below;
          gp_timer_pkg::OM_PWM2: refNext = !below;
          default: refNext = ref_q[g];
        endcase
      end
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          fcnt_q[g] <= '0;
          filt_q[g] <= 1'b0;
          evc_q[g] <= '0;
          ref_q[g] <= 1'b0;
          flag_q[g] <= 1'b0;
          ccr_q[g*CW +: CW] <= `CNT_ZERO;
        end else begin
          // Filter: level must hold flen+1 samples
          if (sync2_q[g] == filt_q[g]) fcnt_q[g] <= '0;
          else if (fcnt_q[g] >= flen) begin
            filt_q[g] <= sync2_q[g];
            fcnt_q[g] <= '0;
          end else fcnt_q[g] <= fcnt_q[g] + `FILT_W'(1);
          if (edgeSeen[g]) evc_q[g] <= capFire[g] ? '0 : evc_q[g] + 1'b1;
          if (capFire[g]) ccr_q[g*CW +: CW] <= cnt_q;
          else if (channelCompareWriteStrobe[g] && !channelIsCapture[g])
            ccr_q[g*CW +: CW] <= chVal(channelCompareWrite, g);
          ref_q[g] <= refNext;
          // Set beats clear
          flag_q[g] <= fire[g] | (flag_q[g] & ~channelFlagClear[g]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      filtPrev_q <= '0;
    end else begin
      sync1_q <= captureIn;
      sync2_q <= sync1_q;
      filtPrev_q <= filt_q;
    end
  end

  wire logic irqNext = |(flag_q & channelIrqEnable);
  wire logic dmaNext = channelDmaSelect && (|flag_q);
  logic irq_q, dma_q;
  logic [NCH-1:0] out_q;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b0;
      dma_q <= 1'b0;
      out_q <= '0;
    end else begin
      irq_q <= irqNext;
      dma_q <= dmaNext;
      out_q <= ref_q ^ channelOutputPolarity;
    end
  end

  assign counterValue = cnt_q;
  assign updateEvent = upd_q;
  assign channelCompareValue = ccr_q;
  assign channelEventFlag = flag_q;
  assign channelReferenceOutput = ref_q;
  assign channelOut = out_q;
  assign irqRequest = irq_q;
  assign dmaRequest = dma_q;

  a_update_blocked: assert property (@(posedge clock) disable iff (!resetn)
    updateDisable |=> !updateEvent) else $error("update while disabled");
  a_run_freeze: assert property (@(posedge clock) disable iff (!resetn)
    !counterRunEnable |=> $stable(counterValue)) else $error("count moved");
  a_up_wrap: assert property (@(posedge clock) disable iff (!resetn)
    ovUp |=> counterValue == `CNT_ZERO) else $error("no wrap to zero");
  a_down_reload: assert property (@(posedge clock) disable iff (!resetn)
    unDn |=> counterValue == $past(arrEff)) else $error("no reload");
  a_update_pulse: assert property (@(posedge clock) disable iff (!resetn)
    (wrap && !updateDisable) |=> updateEvent) else $error("no update");
  a_center_top: assert property (@(posedge clock) disable iff (!resetn)
    ovCa |=> counterValue == $past(arrEff)) else $error("center top");
  a_irq_follow: assert property (@(posedge clock) disable iff (!resetn)
    |(flag_q & channelIrqEnable) |=> irqRequest) else $error("irq missing");
  a_force_hi: assert property (@(posedge clock) disable iff (!resetn)
    channelOutputMode[11:9] == 3'h5 |=> channelReferenceOutput[3])
    else $error("force high failed");

  // Time base checks
  a_up_step: assert property (@(posedge clock) disable iff (!resetn)
    (tick && !center && !isDown && !ovUp) |=>
    counterValue == $past(counterValue) + `CNT_ONE) else $error("up step");
  a_down_step: assert property (@(posedge clock) disable iff (!resetn)
    (tick && isDown && !unDn) |=>
    counterValue == $past(counterValue) - `CNT_ONE) else $error("down step");
  a_center_bottom: assert property (@(posedge clock) disable iff (!resetn)
    unCa |=> counterValue == `CNT_ZERO) else $error("center bottom");
  a_center_fall: assert property (@(posedge clock) disable iff (!resetn)
    ovCa |=> downDir_q) else $error("no turn down");
  a_center_rise: assert property (@(posedge clock) disable iff (!resetn)
    unCa |=> !downDir_q) else $error("no turn up");
  a_hold_notick: assert property (@(posedge clock) disable iff (!resetn)
    !tick |=> $stable(counterValue)) else $error("count off tick");
  a_update_cause: assert property (@(posedge clock) disable iff (!resetn)
    updateEvent |-> $past(wrap)) else $error("stray update");

  // Buffered settings move only on update
  a_psc_load: assert property (@(posedge clock) disable iff (!resetn)
    updNow |=> pscAct_q == $past(prescalerValue))
    else $error("ratio not loaded");
  a_psc_keep: assert property (@(posedge clock) disable iff (!resetn)
    !updNow |=> $stable(pscAct_q)) else $error("ratio moved");
  a_reload_load: assert property (@(posedge clock) disable iff (!resetn)
    updNow |=> arrAct_q == $past(autoReloadValue))
    else $error("reload not loaded");
  a_reload_keep: assert property (@(posedge clock) disable iff (!resetn)
    !updNow |=> $stable(arrAct_q)) else $error("reload moved");

  // Channel checks
  a_capture_latch: assert property (@(posedge clock) disable iff (!resetn)
    capFire[0] |=> channelCompareValue[CW-1:0] == $past(counterValue))
    else $error("capture lost");
  a_refused_write: assert property (@(posedge clock) disable iff (!resetn)
    (channelIsCapture[0] && !capFire[0]) |=>
    $stable(channelCompareValue[CW-1:0])) else $error("capture overwritten");
  a_filter_hold: assert property (@(posedge clock) disable iff (!resetn)
    (sync2_q[0] == filt_q[0]) |=> $stable(filt_q[0]))
    else $error("filter moved");
  a_flag_set: assert property (@(posedge clock) disable iff (!resetn)
    (fire != '0) |=> ((channelEventFlag & $past(fire)) == $past(fire)))
    else $error("flag not set");
  a_flag_hold: assert property (@(posedge clock) disable iff (!resetn)
    (flag_q != '0) |=>
    ((channelEventFlag & $past(flag_q & ~channelFlagClear))
      == $past(flag_q & ~channelFlagClear))) else $error("flag lost");
  a_irq_low: assert property (@(posedge clock) disable iff (!resetn)
    !(|(flag_q & channelIrqEnable)) |=> !irqRequest)
    else $error("stray irq");
  a_dma_follow: assert property (@(posedge clock) disable iff (!resetn)
    (channelDmaSelect && (|flag_q)) |=> dmaRequest)
    else $error("dma missing");
  a_dma_low: assert property (@(posedge clock) disable iff (!resetn)
    !(channelDmaSelect && (|flag_q)) |=> !dmaRequest)
    else $error("stray dma");
  a_out_polarity: assert property (@(posedge clock) disable iff (!resetn)
    1'b1 |=> channelOut == $past(ref_q ^ channelOutputPolarity))
    else $error("polarity wrong");
  a_pwm1_ref: assert property (@(posedge clock) disable iff (!resetn)
    channelOutputMode[2:0] == 3'h6 |=>
    channelReferenceOutput[0] == $past(cnt_q < chVal(ccr_q, 0)))
    else $error("pwm1 level");
  a_pwm2_ref: assert property (@(posedge clock) disable iff (!resetn)
    channelOutputMode[5:3] == 3'h7 |=>
    channelReferenceOutput[1] == $past(cnt_q >= chVal(ccr_q, 1)))
    else $error("pwm2 level");
  a_force_lo: assert property (@(posedge clock) disable iff (!resetn)
    channelOutputMode[8:6] == 3'h4 |=> !channelReferenceOutput[2])
    else $error("force low failed");
endmodule // general_purpose_timer

/* File: sim/capture_pin_model.sv */
// Model of the four capture pins that sit outside the timer.
// Assumes requests are driven off the falling edge of clock.
`timescale 1ns/1ps
module capture_pin_model (
  // Clock
  input wire logic clock,
  // Edge requests from the bench
  input wire logic [3:0] edgeRequest,
  // Pins toward the timer
  output logic [3:0] captureIn
);
  // Pins idle low; each request flips one pin, so one edge per request
  initial captureIn = 4'h0;
  always @(posedge clock) begin
    captureIn <= captureIn ^ edgeRequest;
  end
endmodule // capture_pin_model

/* File: sim/general_purpose_timer_tb.sv */
// Self-checking bench for the general purpose timer.
// Assumes the design and capture_pin_model are compiled first.
`timescale 1ns/1ps
module general_purpose_timer_tb;
  logic clock = 0, resetn = 0, counterRunEnable = 0, updateDisable = 0;
  logic reloadPreloadEnable = 0, channelDmaSelect = 0;
  logic [1:0] countDirectionSelect = 2'h0;
  logic [15:0] autoReloadValue = 16'h0000, prescalerValue = 16'h0000;
  logic [3:0] channelIsCapture = 4'h0, channelCaptureFalling = 4'h0;
  logic [3:0] channelOutputPolarity = 4'h0, channelIrqEnable = 4'h0;
  logic [3:0] channelCompareWriteStrobe = 4'h0, channelFlagClear = 4'h0;
  logic [3:0] edgeRequest = 4'h0;
  logic [15:0] channelFilterLength = 16'h0000;
  logic [7:0] channelEventDivide = 8'h00;
  logic [11:0] channelOutputMode = 12'h000;
  logic [63:0] channelCompareWrite = 64'h0;
  wire [3:0] captureIn, channelEventFlag, channelReferenceOutput, channelOut;
  wire [15:0] counterValue;
  wire [63:0] channelCompareValue;
  wire updateEvent, irqRequest, dmaRequest;
  int seed = 32'hf2ba;
  int mismatches = 0, checkCount = 0, ups, outHighs, highs[4];
  logic [15:0] maxCnt, arr, held;
  int cmp[4] = '{5, 5, 2, 3};
  general_purpose_timer i_dut (.clock(clock), .resetn(resetn),
    .counterRunEnable(counterRunEnable),
    .countDirectionSelect(countDirectionSelect),
    .updateDisable(updateDisable), .reloadPreloadEnable(reloadPreloadEnable),
    .autoReloadValue(autoReloadValue), .prescalerValue(prescalerValue),
    .channelIsCapture(channelIsCapture),
    .channelCaptureFalling(channelCaptureFalling),
    .channelFilterLength(channelFilterLength),
    .channelEventDivide(channelEventDivide),
    .channelOutputMode(channelOutputMode),
    .channelOutputPolarity(channelOutputPolarity),
    .channelIrqEnable(channelIrqEnable), .channelDmaSelect(channelDmaSelect),
    .channelCompareWrite(channelCompareWrite),
    .channelCompareWriteStrobe(channelCompareWriteStrobe),
    .channelFlagClear(channelFlagClear), .captureIn(captureIn),
    .counterValue(counterValue), .updateEvent(updateEvent),
    .channelCompareValue(channelCompareValue),
    .channelEventFlag(channelEventFlag),
    .channelReferenceOutput(channelReferenceOutput),
    .channelOut(channelOut), .irqRequest(irqRequest), .dmaRequest(dmaRequest));
  capture_pin_model i_pins (.clock(clock), .edgeRequest(edgeRequest),
    .captureIn(captureIn));
  always #20 clock = ~clock;
  // High cycles of a reference over n cycles of an up count
  function automatic int expHigh(int m, int c, int a, int n);
    int per;
    per = (m == 6) ? c : (m == 7) ? a + 1 - c : (m == 5) ? a + 1 : 0;
    return per * n / (a + 1);
  endfunction
  task automatic checkValue(string what, logic [15:0] exp, logic [15:0] got);
    checkCount++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic stopTest();
    $display("mismatches %0d checks %0d", mismatches, checkCount);
    if (mismatches == 0 && checkCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One pin edge, then time for sync, filter and flag
  task automatic pulse(input int n);
    edgeRequest = 4'h1;
    @(negedge clock);
    edgeRequest = 4'h0;
    repeat (n) @(negedge clock);
  endtask
  // Second reset between scenarios keeps each one from a known count
  task automatic restart(input logic [1:0] dir, input logic [15:0] a);
    resetn = 0;
    counterRunEnable = 0;
    @(negedge clock);
    resetn = 1;
    countDirectionSelect = dir;
    autoReloadValue = a;
    @(negedge clock);
  endtask
  task automatic writeCompare(input int ch, input logic [15:0] v);
    channelCompareWrite[ch*16+:16] = v;
    channelCompareWriteStrobe[ch] = 1'b1;
    @(negedge clock);
    channelCompareWriteStrobe[ch] = 1'b0;
  endtask
  // Window sums do not depend on the exact output latency
  task automatic window(input int n);
    ups = 0;
    maxCnt = 0;
    outHighs = 0;
    highs = '{0, 0, 0, 0};
    repeat (n) begin
      @(negedge clock);
      ups += int'(updateEvent);
      if (counterValue > maxCnt) maxCnt = counterValue;
      for (int k = 0; k < 4; k++) highs[k] += int'(channelReferenceOutput[k]);
      outHighs += int'(channelOut[1]);
    end
  endtask
  initial begin
    repeat (4) @(negedge clock);
    resetn = 1;
    checkValue("counter at reset", 16'h0000, counterValue);
    checkValue("flags at reset", 16'h0000, {12'h000, channelEventFlag});
    for (int i = 0; i < 4; i++) begin
      arr = 16'($random(seed));
      writeCompare(i, arr);
      @(negedge clock);
      checkValue("compare write", arr, channelCompareValue[i*16+:16]);
    end
    for (int d = 0; d < 2; d++) begin
      arr = 16'h0003 + 16'($random(seed) & 15);
      restart(2'(d), arr);
      counterRunEnable = 1;
      repeat (40) @(negedge clock);
      window(8 * (int'(arr) + 1));
      checkValue("wrap count", 16'h0008, 16'(ups));
      checkValue("top count", arr, maxCnt);
    end
    counterRunEnable = 0;
    @(negedge clock);
    held = counterValue;
    repeat (5) @(negedge clock);
    checkValue("frozen count", held, counterValue);
    restart(2'h2, 16'h0004);
    counterRunEnable = 1;
    repeat (16) @(negedge clock);
    window(32);
    checkValue("center updates", 16'h0008, 16'(ups));
    checkValue("center top", 16'h0004, maxCnt);
    restart(2'h0, 16'h0007);
    channelOutputMode = {3'h5, 3'h4, 3'h7, 3'h6};
    channelOutputPolarity = 4'h2;
    channelIrqEnable = 4'h8;
    channelDmaSelect = 1;
    for (int k = 0; k < 4; k++) writeCompare(k, 16'(cmp[k]));
    counterRunEnable = 1;
    repeat (16) @(negedge clock);
    window(32);
    for (int k = 0; k < 4; k++)
      checkValue("reference highs",
        16'(expHigh(int'(channelOutputMode[k*3+:3]), cmp[k], 7, 32)),
        16'(highs[k]));
    checkValue("inverted out", 16'(32 - highs[1]), 16'(outHighs));
    checkValue("forced flags", 16'h0003, {14'h0, channelEventFlag[3:2]});
    checkValue("irq and dma", 16'h0003, {14'h0, irqRequest, dmaRequest});
    restart(2'h0, 16'h0003);
    channelOutputMode = 12'h000;
    updateDisable = 1;
    prescalerValue = 16'h0001;
    counterRunEnable = 1;
    window(16);
    checkValue("blocked updates", 16'h0000, 16'(ups));
    updateDisable = 0;
    repeat (12) @(negedge clock);
    window(32);
    checkValue("divided updates", 16'h0004, 16'(ups));
    restart(2'h0, 16'h0064);
    channelIsCapture = 4'h1;
    channelIrqEnable = 4'h1;
    counterRunEnable = 1;
    repeat (10) @(negedge clock);
    edgeRequest = 4'h1;
    @(negedge clock);
    edgeRequest = 4'h0;
    for (int t = 0; t < 30 && channelEventFlag[0] !== 1'b1; t++)
      @(negedge clock);
    if (channelEventFlag[0] !== 1'b1) begin
      mismatches++;
      stopTest();
    end
    held = channelCompareValue[15:0];
    @(negedge clock);
    checkValue("capture irq", 16'h0003, {14'h0, irqRequest, dmaRequest});
    checkValue("capture bound", 16'h0001, 16'(held < counterValue));
    writeCompare(0, ~held);
    @(negedge clock);
    checkValue("capture kept", held, channelCompareValue[15:0]);
    channelFlagClear = 4'h1;
    @(negedge clock);
    channelFlagClear = 4'h0;
    edgeRequest = 4'h1;
    @(negedge clock);
    edgeRequest = 4'h0;
    repeat (15) @(negedge clock);
    checkValue("falling ignored", 16'h0000, {15'h0, channelEventFlag[0]});
    checkValue("irq cleared", 16'h0000, {15'h0, irqRequest});
    // Falling edges, filter of four samples, capture every second edge
    channelCaptureFalling = 4'h1;
    channelEventDivide = 8'h01;
    channelFilterLength = 16'h0003;
    pulse(15);
    pulse(15);
    checkValue("first of two", 16'h0000, {15'h0, channelEventFlag[0]});
    pulse(15);
    pulse(15);
    checkValue("second of two", 16'h0001, {15'h0, channelEventFlag[0]});
    stopTest();
  end
endmodule // general_purpose_timer_tb
